// [rtl/sem_core.sv]
// execution unit for extend, multiple load/store and frame enter/leave
`timescale 1ns/10ps
`default_nettype none

module sem_core
    import sem_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    // instruction issue
    input  wire logic               instr_valid,
    input  wire logic [15:0]        instr_code,
    output logic                    instr_ready,
    output logic                    instr_done,
    output logic                    busy,
    // data memory port
    output logic                    mem_req,
    output sem_mem_req_s            mem_out,
    input  wire logic               mem_ready,
    input  wire logic [XLEN-1:0]    mem_rdata,
    // condition flags seen by the rest of the core
    output logic [FLAGS_W-1:0]      cond_flags,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [XLEN-1:0]    pwdata,
    output logic [XLEN-1:0]         prdata,
    output logic                    pready,
    output logic                    pslverr
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // decode one 16-bit instruction into an operation class
    function automatic sem_op_e decode(input logic [15:0] code);
        sem_op_e op;
        op = OP_NONE;
        if (code == CODE_LEAVE) begin
            op = OP_LEAVE;
        end else if (code[15:8] == OPC_ENTER) begin
            op = OP_ENTER;
        end else if (code[15:9] == OPC_LOW_LOAD[7:1]) begin
            op = OP_LOAD;
        end else if (code[15:9] == OPC_LOW_STORE[7:1]) begin
            op = OP_STORE;
        end else if (code[15:8] == OPC_EXTEND) begin
            unique case (code[7:4])
                SUB_BYTE_ZX: op = OP_BYTE_ZX;
                SUB_HALF_SX: op = OP_HALF_SX;
                SUB_HALF_ZX: op = OP_HALF_ZX;
                default:     op = OP_NONE;
            endcase
        end
        return op;
    endfunction : decode

    // index of the lowest set bit of a register-list mask
    function automatic logic [2:0] lowest(input logic [7:0] m);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction : lowest

    // register number a list bit stands for
    function automatic logic [3:0] reg_of(input logic       store,
                                          input logic       high,
                                          input logic [2:0] k);
        logic [3:0] r;
        r = {high, k};
        if (store) begin
            r = {high, ~k};
        end
        return r;
    endfunction : reg_of

    // registers an instruction reads, for the load interlock
    function automatic logic [NREGS-1:0] reads_of(input logic [15:0] code);
        logic [NREGS-1:0] u;
        u = '0;
        unique case (decode(code))
            OP_BYTE_ZX, OP_HALF_SX, OP_HALF_ZX: u[code[3:0]] = 1'b1;
            OP_LOAD:   u[REG_SP] = 1'b1;
            OP_STORE: begin
                u[REG_SP] = 1'b1;
                for (int i = 0; i < 8; i++) begin
                    if (code[i]) begin
                        u[reg_of(1'b1, code[8], 3'(i))] = 1'b1;
                    end
                end
            end
            OP_ENTER: begin
                u[REG_SP] = 1'b1;
                u[REG_FP] = 1'b1;
            end
            OP_LEAVE:  u[REG_FP] = 1'b1;
            OP_NONE:   u = '0;
            default:   u = '0;
        endcase
        return u;
    endfunction : reads_of

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [XLEN-1:0]    regs_q [NREGS];
    logic [XLEN-1:0]    regs_d [NREGS];
    sem_state_e         state_q, state_d;
    logic [7:0]         list_q, list_d;
    logic               high_q, high_d;
    logic               mreq_q, mreq_d;
    sem_mem_req_s       mem_q, mem_d;
    logic [NREGS-1:0]   loaded_q, loaded_d;
    logic [FLAGS_W-1:0] flags_q, flags_d;
    logic [XLEN-1:0]    prdata_q, prdata_d;
    logic               pslverr_q, pslverr_d;

    sem_op_e            op;
    logic               leave_now;
    logic               apb_access;
    logic [2:0]         k;
    logic [3:0]         r;
    logic [7:0]         rest;
    logic [31:0]        sp;
    logic [31:0]        fp;
    logic [31:0]        frame_bytes;

    // ------------------------------------------------------------------
    // next-state logic: instruction sequencing, register file, APB
    // ------------------------------------------------------------------
    always_comb begin
        regs_d      = regs_q;
        state_d     = state_q;
        list_d      = list_q;
        high_d      = high_q;
        mreq_d      = mreq_q;
        mem_d       = mem_q;
        loaded_d    = loaded_q;
        flags_d     = flags_q;
        prdata_d    = prdata_q;
        pslverr_d   = pslverr_q;
        instr_ready = 1'b0;
        instr_done  = 1'b0;
        leave_now   = 1'b0;
        op          = decode(instr_code);
        sp          = regs_q[REG_SP];
        fp          = regs_q[REG_FP];
        k           = lowest(list_q);
        r           = reg_of(state_q == ST_STORE, high_q, k);
        rest        = list_q & ~(8'h01 << k);
        frame_bytes = {22'h0, instr_code[7:0], 2'b00};
        apb_access  = psel && penable && (state_q == ST_IDLE);

        // software writes only land between instructions
        if (apb_access && pwrite) begin
            if (paddr <= ADDR_GPR_LAST) begin
                regs_d[paddr[5:2]] = pwdata;
            end else if (paddr == ADDR_FLAGS) begin
                flags_d = pwdata[FLAGS_W-1:0];
            end
        end

        unique case (state_q)
            ST_IDLE: begin
                // the interlock only reaches the very next instruction
                loaded_d = '0;
                instr_ready = !psel && ((reads_of(instr_code) & loaded_q) == '0);
                if (instr_valid && instr_ready) begin
                    unique case (op)
                        OP_BYTE_ZX: begin
                            regs_d[instr_code[3:0]] =
                                {24'h0, regs_q[instr_code[3:0]][7:0]};
                            instr_done = 1'b1;
                        end
                        OP_HALF_SX: begin
                            regs_d[instr_code[3:0]] =
                                {{16{regs_q[instr_code[3:0]][15]}},
                                 regs_q[instr_code[3:0]][15:0]};
                            instr_done = 1'b1;
                        end
                        OP_HALF_ZX: begin
                            regs_d[instr_code[3:0]] =
                                {16'h0, regs_q[instr_code[3:0]][15:0]};
                            instr_done = 1'b1;
                        end
                        OP_LOAD: begin
                            // empty list is one idle cycle
                            if (instr_code[7:0] == 8'h00) begin
                                instr_done = 1'b1;
                            end else begin
                                state_d    = ST_LOAD;
                                list_d     = instr_code[7:0];
                                high_d     = instr_code[8];
                                mreq_d     = 1'b1;
                                mem_d.we   = 1'b0;
                                mem_d.addr = sp;
                            end
                        end
                        OP_STORE: begin
                            // empty list is one idle cycle
                            if (instr_code[7:0] == 8'h00) begin
                                instr_done = 1'b1;
                            end else begin
                                state_d       = ST_STORE;
                                list_d        = instr_code[7:0];
                                high_d        = instr_code[8];
                                mreq_d        = 1'b1;
                                regs_d[REG_SP] = sp - WORD_BYTES;
                                mem_d.we      = 1'b1;
                                mem_d.addr    = sp - WORD_BYTES;
                                // pointer word taken before any step
                                mem_d.wdata   = regs_q[reg_of(1'b1,
                                    instr_code[8], lowest(instr_code[7:0]))];
                            end
                        end
                        OP_ENTER: begin
                            state_d        = ST_ENTER;
                            mreq_d         = 1'b1;
                            mem_d.we       = 1'b1;
                            mem_d.addr     = sp - WORD_BYTES;
                            mem_d.wdata    = fp;
                            regs_d[REG_FP] = sp - WORD_BYTES;
                            regs_d[REG_SP] = sp - frame_bytes;
                        end
                        // leave reads at frame pointer at once
                        OP_LEAVE: begin
                            leave_now = 1'b1;
                            if (mem_ready) begin
                                regs_d[REG_SP] = fp + WORD_BYTES;
                                regs_d[REG_FP] = mem_rdata;
                                loaded_d[REG_FP] = 1'b1;
                                instr_done = 1'b1;
                            end else begin
                                state_d = ST_LEAVE;
                                mreq_d  = 1'b1;
                            end
                        end
                        // foreign codes retire as a no-op
                        default: instr_done = 1'b1;
                    endcase
                end
            end
            ST_LOAD: begin
                if (mem_ready) begin
                    regs_d[REG_SP] = sp + WORD_BYTES;
                    regs_d[r]   = mem_rdata;
                    loaded_d[r] = 1'b1;
                    list_d      = rest;
                    mem_d.addr  = sp + WORD_BYTES;
                    if (rest == 8'h00) begin
                        state_d    = ST_IDLE;
                        mreq_d     = 1'b0;
                        instr_done = 1'b1;
                    end
                end
            end
            ST_STORE: begin
                if (mem_ready) begin
                    list_d = rest;
                    if (rest == 8'h00) begin
                        state_d    = ST_IDLE;
                        mreq_d     = 1'b0;
                        instr_done = 1'b1;
                    end else begin
                        regs_d[REG_SP] = sp - WORD_BYTES;
                        mem_d.addr     = sp - WORD_BYTES;
                        mem_d.wdata    = regs_q[reg_of(1'b1, high_q,
                                                       lowest(rest))];
                    end
                end
            end
            ST_ENTER: begin
                if (mem_ready) begin
                    state_d    = ST_IDLE;
                    mreq_d     = 1'b0;
                    instr_done = 1'b1;
                end
            end
            ST_LEAVE: begin
                if (mem_ready) begin
                    regs_d[REG_SP]   = fp + WORD_BYTES;
                    regs_d[REG_FP]   = mem_rdata;
                    loaded_d[REG_FP] = 1'b1;
                    state_d          = ST_IDLE;
                    mreq_d           = 1'b0;
                    instr_done       = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                mreq_d  = 1'b0;
            end
        endcase

        // idle address tracks the frame pointer so leave can start at once
        if (state_d == ST_IDLE) begin
            mem_d.we   = 1'b0;
            mem_d.addr = regs_d[REG_FP];
        end

        // read data captured from next values so it is current at pready
        if (psel && !apb_access) begin
            pslverr_d = 1'b0;
            prdata_d  = '0;
            if (paddr[1:0] != 2'b00) begin
                pslverr_d = 1'b1;
            end else if (paddr <= ADDR_GPR_LAST) begin
                prdata_d = regs_d[paddr[5:2]];
            end else if (paddr == ADDR_FLAGS) begin
                prdata_d[FLAGS_W-1:0] = flags_d;
            end else if (paddr == ADDR_STATUS) begin
                prdata_d[STAT_BUSY_BIT] = (state_d != ST_IDLE);
                prdata_d[STAT_ST_LSB +: 5] = state_d;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_q[i] <= '0;
            end
            state_q   <= ST_IDLE;
            list_q    <= 8'h00;
            high_q    <= 1'b0;
            mreq_q    <= 1'b0;
            mem_q     <= '0;
            loaded_q  <= '0;
            flags_q   <= '0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            regs_q    <= regs_d;
            state_q   <= state_d;
            list_q    <= list_d;
            high_q    <= high_d;
            mreq_q    <= mreq_d;
            mem_q     <= mem_d;
            loaded_q  <= loaded_d;
            flags_q   <= flags_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // one request held until ready
    assign mem_req    = mreq_q | leave_now;
    assign mem_out    = mem_q;
    assign busy       = (state_q != ST_IDLE);
    assign cond_flags = flags_q;
    // APB waits while an instruction is in flight
    assign pready     = (state_q == ST_IDLE);
    assign prdata     = prdata_q;
    assign pslverr    = pslverr_q && pready && psel && penable;

endmodule : sem_core

`default_nettype wire

// [rtl/sem_pkg.sv]
// shared constants, types and encodings of the stack/extend/multiple unit
package sem_pkg;

    // ------------------------------------------------------------------
    // data path geometry
    // ------------------------------------------------------------------
    localparam int          XLEN       = 32;
    localparam int          NREGS      = 16;
    localparam int          FLAGS_W    = 4;
    localparam logic [3:0]  REG_SP     = 4'hF;   // stack_pointer_reg
    localparam logic [3:0]  REG_FP     = 4'hE;   // frame_pointer_reg
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    // ------------------------------------------------------------------
    // instruction encodings (upper byte, sub-op nibble, fixed pattern)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPC_LOW_LOAD   = 8'h8C;
    localparam logic [7:0]  OPC_HIGH_LOAD  = 8'h8D;
    localparam logic [7:0]  OPC_LOW_STORE  = 8'h8E;
    localparam logic [7:0]  OPC_HIGH_STORE = 8'h8F;
    localparam logic [7:0]  OPC_ENTER      = 8'h0F;
    localparam logic [7:0]  OPC_EXTEND     = 8'h97;
    localparam logic [3:0]  SUB_BYTE_ZX    = 4'hA;
    localparam logic [3:0]  SUB_HALF_SX    = 4'hB;
    localparam logic [3:0]  SUB_HALF_ZX    = 4'hC;
    localparam logic [15:0] CODE_LEAVE     = 16'h9F90;

    // ------------------------------------------------------------------
    // register map on the APB slave (byte addresses)
    // ------------------------------------------------------------------
    localparam int          PADDR_W       = 8;
    localparam logic [7:0]  ADDR_GPR_LAST = 8'h3C;
    localparam logic [7:0]  ADDR_FLAGS    = 8'h40;
    localparam logic [7:0]  ADDR_STATUS   = 8'h44;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_ST_LSB   = 4;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LOAD  = 5'b00010,
        ST_STORE = 5'b00100,
        ST_ENTER = 5'b01000,
        ST_LEAVE = 5'b10000
    } sem_state_e;

    typedef enum logic [3:0] {
        OP_NONE, OP_BYTE_ZX, OP_HALF_SX, OP_HALF_ZX,
        OP_LOAD, OP_STORE, OP_ENTER, OP_LEAVE
    } sem_op_e;

    // one word access toward data memory
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sem_mem_req_s;

endpackage : sem_pkg

// [verification/sem_mem_model.sv]
// data memory model answering the unit's word accesses
`timescale 1ns/10ps
`default_nettype none
module sem_mem_model
    import sem_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            mem_req,
    input  wire sem_mem_req_s    mem_out,
    input  wire logic [1:0]      mem_wait,
    output logic                 mem_ready,
    output logic [XLEN-1:0]      mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  wait_q;
    logic [31:0] rd_q;
    // one word per access, ready after mem_wait stalls
    always_comb begin
        mem_ready = mem_req && (wait_q == mem_wait);
        mem_rdata = ~rd_q;  // off-access data keeps moving
        if (mem_ready && !mem_out.we && mem.exists(mem_out.addr))
            mem_rdata = mem[mem_out.addr];
    end
    // stall counter and write port
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 2'h0;
            rd_q   <= 32'h0;
        end else begin
            rd_q   <= mem_rdata;
            wait_q <= (mem_req && !mem_ready) ? wait_q + 2'h1 : 2'h0;
            if (mem_ready && mem_out.we)
                mem[mem_out.addr] = mem_out.wdata;
        end
    end
endmodule : sem_mem_model
`default_nettype wire

// [verification/sem_core_sva.sv]
// port-level checker for the stack, extend and multiple unit
`timescale 1ns/10ps
`default_nettype none
module sem_core_sva
    import sem_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               instr_valid,
    input wire logic [15:0]        instr_code,
    input wire logic               instr_ready,
    input wire logic               instr_done,
    input wire logic               busy,
    input wire logic               mem_req,
    input wire sem_mem_req_s       mem_out,
    input wire logic               mem_ready,
    input wire logic [FLAGS_W-1:0] cond_flags,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic               pready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic nomask;
    logic is_ld;
    logic is_st;
    // decode of the offered word, for antecedents only
    assign acc    = instr_valid && instr_ready;
    assign nomask = instr_code[7:0] == 8'h00;
    assign is_ld  = instr_code[15:9] == OPC_LOW_LOAD[7:1];
    assign is_st  = instr_code[15:9] == OPC_LOW_STORE[7:1];
    a_flags_held: assert property (
        !(psel && penable && pready && pwrite) |=> $stable(cond_flags))
        else $error("flags moved without a write");
    a_extend_single: assert property (
        acc && instr_code[15:8] == OPC_EXTEND |-> instr_done)
        else $error("extend not done in one cycle");
    a_empty_load: assert property (
        acc && is_ld && nomask |-> instr_done ##1 !mem_req)
        else $error("empty load not quick");
    a_empty_store: assert property (
        acc && is_st && nomask |-> instr_done ##1 !mem_req)
        else $error("empty store accessed memory");
    a_load_first: assert property (
        acc && is_ld && !nomask |=> mem_req && !mem_out.we)
        else $error("load did not read");
    a_store_first: assert property (
        acc && is_st && !nomask |=> mem_req && mem_out.we)
        else $error("store did not write");
    a_enter_write: assert property (
        acc && instr_code[15:8] == OPC_ENTER |=> mem_req && mem_out.we)
        else $error("frame enter did not write");
    a_leave_read: assert property (
        acc && instr_code == CODE_LEAVE |-> mem_req && !mem_out.we)
        else $error("frame leave did not read");
    a_req_held: assert property (
        busy && mem_req && !mem_ready |=> mem_req && $stable(mem_out))
        else $error("access dropped before ready");
    a_store_step: assert property (
        busy && mem_req && mem_ready && mem_out.we ##1
        busy && mem_req && mem_out.we
        |-> mem_out.addr == $past(mem_out.addr) - WORD_BYTES)
        else $error("store step not minus four");
    a_load_step: assert property (
        busy && mem_req && mem_ready && !mem_out.we ##1
        busy && mem_req && !mem_out.we
        |-> mem_out.addr == $past(mem_out.addr) + WORD_BYTES)
        else $error("load step not plus four");
    a_done_ready: assert property (
        busy && instr_done |-> mem_req && mem_ready)
        else $error("retired off the last access");
endmodule : sem_core_sva
bind sem_core sem_core_sva u_sva (.pclk, .presetn, .instr_valid,
    .instr_code, .instr_ready, .instr_done, .busy, .mem_req, .mem_out,
    .mem_ready, .cond_flags, .psel, .penable, .pwrite, .pready);
`default_nettype wire

// [verification/sem_core_tb.sv]
// self-checking bench for the stack, extend and multiple unit
`timescale 1ns/10ps
`default_nettype none
module sem_core_tb
    import sem_pkg::*;
;
    logic pclk, presetn, instr_valid, instr_ready, instr_done, busy;
    logic mem_req, mem_ready, psel, penable, pwrite, pready, pslverr;
    logic [15:0]  instr_code;
    logic [1:0]   mem_wait;
    logic [7:0]   paddr;
    logic [31:0]  mem_rdata, pwdata, prdata, v, r8, cyc;
    logic [3:0]   cond_flags;
    logic         perr;
    sem_mem_req_s mem_out;
    logic [31:0]  exp_q[$];
    int           num_errors, checks, dones;
    sem_core DUT (.pclk, .presetn, .instr_valid, .instr_code, .instr_ready,
        .instr_done, .busy, .mem_req, .mem_out, .mem_ready, .mem_rdata,
        .cond_flags, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    sem_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_out, .mem_wait,
        .mem_ready, .mem_rdata);
    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic tmo(input int n);
        if (n >= 99) begin
            num_errors++;
            end_sim();
        end
    endtask : tmo
    // one apb transfer; held until pready seen at the closing edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (!pready && n < 99) begin
            @(negedge pclk);
            n++;
        end
        tmo(n);
        perr = pslverr;
        @(posedge pclk);
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // offer one instruction; the monitor times it from the accept edge
    task automatic issue(input logic [15:0] c, input logic [31:0] e);
        int n;
        int k;
        n = 0;
        k = dones;
        exp_q.push_back(e);
        @(posedge pclk);
        {instr_valid, instr_code} <= {1'b1, c};
        @(negedge pclk);
        while (!instr_ready && n < 99) begin
            @(negedge pclk);
            n++;
        end
        @(posedge pclk);
        instr_valid <= 1'b0;
        while (dones == k && n < 99) begin
            @(negedge pclk);
            n++;
        end
        tmo(n);
    endtask : issue
    // monitor: settled values at the falling edge, oldest note first
    always @(negedge pclk) begin
        cyc = (instr_valid && instr_ready) ? 32'h1 : cyc + 32'h1;
        if (instr_done) dones++;
        if (instr_done) chk(cyc, exp_q.pop_front());
        if (psel && penable && pready && !pwrite)
            chk(prdata, exp_q.pop_front());
    end
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {presetn, instr_valid, psel, penable, pwrite} = 5'h0;
        {instr_code, paddr, pwdata, mem_wait} = 58'h0;
        void'($urandom(32'hEF1B87B9));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_FLAGS, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'hA);
        apb(1'b1, 8'h80, 32'h5);
        chk({31'h0, perr}, 32'h1);
        v = $urandom() | 32'h0000_8080;
        for (int i = 1; i < 4; i++) apb(1'b1, 8'(i * 4), v);
        issue({OPC_EXTEND, SUB_BYTE_ZX, 4'h1}, 1);
        issue({OPC_EXTEND, SUB_HALF_SX, 4'h2}, 1);
        issue({OPC_EXTEND, SUB_HALF_ZX, 4'h3}, 1);
        rd(8'h04, {24'h0, v[7:0]});
        rd(8'h08, {{16{v[15]}}, v[15:0]});
        rd(8'h0C, {16'h0, v[15:0]});
        issue(16'h0000, 1);
        // prompt then stalling memory, a = w + 1
        for (int w = 0; w < 2; w++) begin
            @(posedge pclk);
            mem_wait <= 2'(w);
            r8 = $urandom() & 32'hFFFF_FFFC;
            apb(1'b1, 8'h3C, 32'h100);
            apb(1'b1, 8'h20, r8);
            issue({OPC_HIGH_STORE, 8'h81}, 3 + 2 * w);
            issue({OPC_LOW_LOAD, 8'h03}, 3 + 2 * w);
            rd(8'h00, r8);
            rd(8'h04, 32'h100);
            rd(8'h3C, 32'h100);
            issue({OPC_LOW_STORE, 8'h80}, 2 + w);
            issue({OPC_HIGH_LOAD, 8'h80}, 2 + w);
            rd(8'h3C, r8);
            issue({OPC_LOW_LOAD, 8'h00}, 1);
            issue({OPC_HIGH_STORE, 8'h00}, 1);
            rd(8'h3C, r8);
            apb(1'b1, 8'h3C, 32'h7FFF_FFF8);
            apb(1'b1, 8'h38, 32'h8000_0000);
            issue({OPC_ENTER, 8'h83}, 2 + w);
            rd(8'h38, 32'h7FFF_FFF4);
            rd(8'h3C, 32'h7FFF_FDEC);
            issue(CODE_LEAVE, 1 + w);
            rd(8'h38, 32'h8000_0000);
            rd(8'h3C, 32'h7FFF_FFF8);
        end
        rd(ADDR_FLAGS, 32'hA);
        end_sim();
    end
endmodule : sem_core_tb
`default_nettype wire
